/* File: common/zone_jam_pkg.sv */
// Shared constants and types for the zone jam option logic
package zone_jam_pkg;
	// Timing
	localparam int CLK_NS = 5;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int TICK_W = 18;
	localparam logic [15:0] ATTEMPT_MS = 16'h03E8;
	localparam logic [1:0] MAX_ATTEMPTS = 2'h3;
	localparam logic [15:0] TIMER_MAX = 16'hFFFF;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_JAM_TIME = 8'h04;
	localparam logic [7:0] OFS_CLR_DELAY = 8'h08;
	localparam logic [7:0] OFS_CMD = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_COUNT = 8'h14;
	localparam logic [7:0] OFS_IRQ_ST = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] JAM_TIME_RST = 16'h0FA0;
	localparam logic [15:0] CLR_DELAY_RST = 16'h1388;
	// Option bits within a zone's byte of the control register
	localparam int OPT_BYP_ARR = 0;
	localparam int OPT_BYP_SNS = 1;
	localparam int OPT_NO_AUTO = 2;
	localparam int OPT_NO_ARRTO = 3;
	localparam int OPT_NO_MANUAL = 4;
	localparam int ZONE_STRIDE = 8;
	localparam int LEFT_SEL_BIT = 16;
	localparam int NZ = 2;
	// Synchronised input positions
	localparam int SY_SNS = 0;
	localparam int SY_ACC = 2;
	localparam int SY_DN_ARR = 4;
	localparam int SY_DN_RDY = 5;
	localparam int SY_UP_LOST = 6;
	localparam int SYNC_W = 7;
	// Zone states
	typedef enum logic [7:0] {
		ZS_EMPTY = 8'h01,
		ZS_HELD = 8'h02,
		ZS_SEND = 8'h04,
		ZS_WAIT_ARR = 8'h08,
		ZS_SEARCH = 8'h10,
		ZS_JAM_ARR = 8'h20,
		ZS_JAM_SNS = 8'h40,
		ZS_CLEAR_RUN = 8'h80
	} zone_state_e;
	typedef struct packed {
		zone_state_e state;
		logic [15:0] timer;
		logic [1:0] attempts;
		logic [15:0] count;
	} zone_s;
endpackage

/* File: common/sync_if.sv */
// Carrier between the pin synchroniser and the zone logic
`timescale 1ns/1ps
interface sync_if;
	logic [zone_jam_pkg::SYNC_W-1:0] raw;
	logic [zone_jam_pkg::SYNC_W-1:0] sync;
	logic tick;
	modport src (input raw, output sync, output tick);
	modport dst (output raw, input sync, input tick);
endinterface

/* File: hdl/pin_sync_tick.sv */
// Two-stage pin synchroniser and millisecond tick divider
`timescale 1ns/1ps
module pin_sync_tick #(
	parameter int TICK_CYCLES = zone_jam_pkg::TICK_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Synchronised pins and tick
	sync_if.src sif
);
	typedef struct packed {
		logic [zone_jam_pkg::SYNC_W-1:0] s1;
		logic [zone_jam_pkg::SYNC_W-1:0] s2;
		logic [zone_jam_pkg::TICK_W-1:0] cnt;
		logic tick;
	} st_s;
	st_s st;
	st_s next_st;

	// First stage feeds only the second stage
	always_comb begin
		next_st = st;
		next_st.s1 = sif.raw;
		next_st.s2 = st.s1;
		next_st.tick = 1'b0;
		if (st.cnt == zone_jam_pkg::TICK_W'(TICK_CYCLES - 1)) begin
			next_st.cnt = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sif.sync = st.s2;
	assign sif.tick = st.tick;
endmodule // pin_sync_tick

/* File: hdl/zone_jam_ctrl.sv */
// Two-zone conveyor jam handling with per-zone options and APB registers
//
// Summary of operation
// - Each zone has separate options to skip the auto clear delay for arrival jams and for sensor jams.
// - Skipping the delay still detects, flags and counts the jam, then clears it at once.
// - A sensor jam by default gets up to three automatic clearing attempts.
// - With auto clear disabled a sensor jam stays until the sensor clears by hand or a clear command starts an attempt.
// - A clear command to a zone starts a clearing attempt on its active sensor jam.
// - After discharge the zone waits up to its jam time for arrival, else raises an arrival jam.
// - With the arrival timeout disabled the zone never raises an arrival jam.
// - With the arrival timeout disabled the zone accepts again as soon as its carton has left.
// - A carton taken by hand from an accumulated zone makes the zone downstream run a search.
// - With manual handling disabled the zone does not run when its upstream loses such a carton.
// - Motors map to the left and right ports independent of the flow direction.
// - Each zone counts all jams since reset and shows an active-jam indicator.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module zone_jam_ctrl #(
	parameter int TICK_CYCLES = zone_jam_pkg::TICK_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Zone sensors and accumulate inputs, index 0 upstream
	input wire logic [1:0] zone_sensor,
	input wire logic [1:0] zone_accumulate,
	// Neighbour module links
	input wire logic dn_arrived,
	input wire logic dn_ready,
	input wire logic up_lost,
	output logic arrived_to_up,
	output logic ready_to_up,
	output logic lost_to_dn,
	// Motor ports and interrupt
	output logic motor_run_left,
	output logic motor_run_right,
	output logic irq
);
	typedef zone_jam_pkg::zone_state_e zs_e;
	typedef struct packed {
		zone_jam_pkg::zone_s [1:0] z;
		logic [31:0] ctrl;
		logic [15:0] jam_time;
		logic [15:0] clr_delay;
		logic [1:0] clear_req;
		logic [3:0] irq_st;
		logic [3:0] irq_mask;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		logic motor_left;
		logic motor_right;
		logic arr_up;
		logic rdy_up;
		logic lost_dn;
	} st_s;
	st_s st;
	st_s next_st;
	sync_if sif ();
	logic [1:0] sns;
	logic [1:0] accu;
	logic [1:0] dn_arr;
	logic [1:0] dn_rdy;
	logic [1:0] lost_in;
	logic [3:0] jam_ev;
	logic [3:0] w1c;
	logic lost0;

	pin_sync_tick #(.TICK_CYCLES(TICK_CYCLES)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.sif(sif)
	);

	// Pin bundle into the synchroniser
	assign sif.raw = {up_lost, dn_ready, dn_arrived, zone_accumulate, zone_sensor};

	// Option bit of one zone
	function automatic logic opt(input logic [31:0] c, input int z, input int b);
		return c[z * zone_jam_pkg::ZONE_STRIDE + b];
	endfunction

	// Zone holds a carton
	function automatic logic loaded(input zs_e s);
		return !(s inside {zone_jam_pkg::ZS_EMPTY, zone_jam_pkg::ZS_SEARCH});
	endfunction

	// Zone motor runs
	function automatic logic running(input zs_e s);
		return s inside {zone_jam_pkg::ZS_SEND, zone_jam_pkg::ZS_WAIT_ARR,
			zone_jam_pkg::ZS_SEARCH, zone_jam_pkg::ZS_CLEAR_RUN};
	endfunction

	// Mapped register offset
	function automatic logic reg_hit(input logic [7:0] a);
		return a inside {zone_jam_pkg::OFS_CTRL, zone_jam_pkg::OFS_JAM_TIME, zone_jam_pkg::OFS_CLR_DELAY,
			zone_jam_pkg::OFS_CMD, zone_jam_pkg::OFS_STATUS, zone_jam_pkg::OFS_COUNT,
			zone_jam_pkg::OFS_IRQ_ST, zone_jam_pkg::OFS_IRQ_MASK};
	endfunction

	// Per-zone view of sensors and neighbours; zone 0 sees zone 1 downstream
	assign sns = sif.sync[zone_jam_pkg::SY_SNS +: 2];
	assign accu = sif.sync[zone_jam_pkg::SY_ACC +: 2];
	assign dn_arr = {sif.sync[zone_jam_pkg::SY_DN_ARR], loaded(st.z[1].state)};
	assign dn_rdy = {sif.sync[zone_jam_pkg::SY_DN_RDY], st.z[1].state == zone_jam_pkg::ZS_EMPTY};
	assign lost0 = st.z[0].state == zone_jam_pkg::ZS_HELD && accu[0] && !sns[0];
	assign lost_in = {lost0, sif.sync[zone_jam_pkg::SY_UP_LOST]};

	// Zone state machines, register file and outputs
	always_comb begin
		next_st = st;
		jam_ev = '0;
		w1c = '0;
		for (int z = 0; z < zone_jam_pkg::NZ; z++) begin
			if (sif.tick && st.z[z].timer != zone_jam_pkg::TIMER_MAX) begin
				next_st.z[z].timer = st.z[z].timer + 16'h0001;
			end
			unique case (st.z[z].state)
				zone_jam_pkg::ZS_EMPTY: begin
					if (sns[z]) begin
						next_st.z[z].state = zone_jam_pkg::ZS_HELD;
					end else if (lost_in[z] && !opt(st.ctrl, z, zone_jam_pkg::OPT_NO_MANUAL)) begin
						next_st.z[z].state = zone_jam_pkg::ZS_SEARCH;
						next_st.z[z].timer = '0;
					end
				end
				zone_jam_pkg::ZS_HELD: begin
					if (!sns[z]) begin
						next_st.z[z].state = zone_jam_pkg::ZS_EMPTY;
					end else if (!accu[z] && dn_rdy[z]) begin
						next_st.z[z].state = zone_jam_pkg::ZS_SEND;
						next_st.z[z].timer = '0;
					end
				end
				zone_jam_pkg::ZS_SEND: begin
					if (!sns[z]) begin
						next_st.z[z].timer = '0;
						if (opt(st.ctrl, z, zone_jam_pkg::OPT_NO_ARRTO)) begin
							next_st.z[z].state = zone_jam_pkg::ZS_EMPTY;
						end else begin
							next_st.z[z].state = zone_jam_pkg::ZS_WAIT_ARR;
						end
					end else if (st.z[z].timer >= st.jam_time) begin
						next_st.z[z].state = zone_jam_pkg::ZS_JAM_SNS;
						next_st.z[z].timer = '0;
						next_st.z[z].attempts = '0;
						next_st.z[z].count = st.z[z].count + 16'h0001;
						jam_ev[2 * z + 1] = 1'b1;
					end
				end
				zone_jam_pkg::ZS_WAIT_ARR: begin
					if (dn_arr[z] || opt(st.ctrl, z, zone_jam_pkg::OPT_NO_ARRTO)) begin
						next_st.z[z].state = zone_jam_pkg::ZS_EMPTY;
					end else if (st.z[z].timer >= st.jam_time) begin
						next_st.z[z].state = zone_jam_pkg::ZS_JAM_ARR;
						next_st.z[z].timer = '0;
						next_st.z[z].count = st.z[z].count + 16'h0001;
						jam_ev[2 * z] = 1'b1;
					end
				end
				zone_jam_pkg::ZS_SEARCH: begin
					if (sns[z]) begin
						next_st.z[z].state = zone_jam_pkg::ZS_HELD;
					end else if (st.z[z].timer >= st.jam_time) begin
						next_st.z[z].state = zone_jam_pkg::ZS_EMPTY;
					end
				end
				zone_jam_pkg::ZS_JAM_ARR: begin
					// Jam stays flagged for one cycle even when the delay is skipped
					if (opt(st.ctrl, z, zone_jam_pkg::OPT_BYP_ARR) || st.z[z].timer >= st.clr_delay) begin
						next_st.z[z].state = zone_jam_pkg::ZS_EMPTY;
					end
				end
				zone_jam_pkg::ZS_JAM_SNS: begin
					if (!sns[z]) begin
						next_st.z[z].state = zone_jam_pkg::ZS_EMPTY;
					end else if (st.clear_req[z]) begin
						next_st.z[z].state = zone_jam_pkg::ZS_CLEAR_RUN;
						next_st.z[z].timer = '0;
					end else if (!opt(st.ctrl, z, zone_jam_pkg::OPT_NO_AUTO)
						&& st.z[z].attempts < zone_jam_pkg::MAX_ATTEMPTS
						&& (opt(st.ctrl, z, zone_jam_pkg::OPT_BYP_SNS) || st.z[z].timer >= st.clr_delay)) begin
						next_st.z[z].state = zone_jam_pkg::ZS_CLEAR_RUN;
						next_st.z[z].timer = '0;
						next_st.z[z].attempts = st.z[z].attempts + 2'h1;
					end
				end
				zone_jam_pkg::ZS_CLEAR_RUN: begin
					if (!sns[z]) begin
						next_st.z[z].state = zone_jam_pkg::ZS_EMPTY;
					end else if (st.z[z].timer >= zone_jam_pkg::ATTEMPT_MS) begin
						next_st.z[z].state = zone_jam_pkg::ZS_JAM_SNS;
						next_st.z[z].timer = '0;
					end
				end
				default: begin
					next_st.z[z].state = zone_jam_pkg::ZS_EMPTY;
				end
			endcase
		end
		// APB: one wait state, answer registered
		next_st.clear_req = '0;
		next_st.pready = psel && penable && !st.pready;
		if (psel && penable && !st.pready) begin
			next_st.pslverr = !reg_hit(paddr);
			unique case (paddr)
				zone_jam_pkg::OFS_CTRL: next_st.prdata = st.ctrl;
				zone_jam_pkg::OFS_JAM_TIME: next_st.prdata = {16'h0000, st.jam_time};
				zone_jam_pkg::OFS_CLR_DELAY: next_st.prdata = {16'h0000, st.clr_delay};
				zone_jam_pkg::OFS_STATUS: next_st.prdata = {24'h000000, st.z[1].attempts, st.z[0].attempts,
					loaded(st.z[1].state), loaded(st.z[0].state),
					st.z[1].state inside {zone_jam_pkg::ZS_JAM_ARR, zone_jam_pkg::ZS_JAM_SNS},
					st.z[0].state inside {zone_jam_pkg::ZS_JAM_ARR, zone_jam_pkg::ZS_JAM_SNS}};
				zone_jam_pkg::OFS_COUNT: next_st.prdata = {st.z[1].count, st.z[0].count};
				zone_jam_pkg::OFS_IRQ_ST: next_st.prdata = {28'h0000000, st.irq_st};
				zone_jam_pkg::OFS_IRQ_MASK: next_st.prdata = {28'h0000000, st.irq_mask};
				default: next_st.prdata = '0;
			endcase
		end
		if (psel && penable && st.pready && pwrite && reg_hit(paddr)) begin
			unique case (paddr)
				zone_jam_pkg::OFS_CTRL: next_st.ctrl = pwdata & 32'h0001_1F1F;
				zone_jam_pkg::OFS_JAM_TIME: next_st.jam_time = pwdata[15:0];
				zone_jam_pkg::OFS_CLR_DELAY: next_st.clr_delay = pwdata[15:0];
				zone_jam_pkg::OFS_CMD: next_st.clear_req = pwdata[1:0];
				zone_jam_pkg::OFS_IRQ_ST: w1c = pwdata[3:0];
				zone_jam_pkg::OFS_IRQ_MASK: next_st.irq_mask = pwdata[3:0];
				default: next_st.clear_req = '0;
			endcase
		end
		// Sticky jam events, a new event beats the clear
		next_st.irq_st = (st.irq_st & ~w1c) | jam_ev;
		next_st.irq = |(next_st.irq_st & next_st.irq_mask);
		// Port mapping by physical side
		next_st.motor_left = running(next_st.z[next_st.ctrl[zone_jam_pkg::LEFT_SEL_BIT]].state);
		next_st.motor_right = running(next_st.z[!next_st.ctrl[zone_jam_pkg::LEFT_SEL_BIT]].state);
		next_st.arr_up = loaded(next_st.z[0].state);
		next_st.rdy_up = next_st.z[0].state == zone_jam_pkg::ZS_EMPTY;
		// Lost pulse stretched to the next tick for the neighbour's synchroniser
		if (st.z[1].state == zone_jam_pkg::ZS_HELD && accu[1] && !sns[1]) begin
			next_st.lost_dn = 1'b1;
		end else if (sif.tick) begin
			next_st.lost_dn = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.z[0].state <= zone_jam_pkg::ZS_EMPTY;
			st.z[1].state <= zone_jam_pkg::ZS_EMPTY;
			st.ctrl <= zone_jam_pkg::CTRL_RST;
			st.jam_time <= zone_jam_pkg::JAM_TIME_RST;
			st.clr_delay <= zone_jam_pkg::CLR_DELAY_RST;
			st.rdy_up <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign motor_run_left = st.motor_left;
	assign motor_run_right = st.motor_right;
	assign irq = st.irq;
	assign arrived_to_up = st.arr_up;
	assign ready_to_up = st.rdy_up;
	assign lost_to_dn = st.lost_dn;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Per-zone checks
	for (genvar g = 0; g < zone_jam_pkg::NZ; g++) begin : g_chk
		zs_e zs;
		logic no_arrto;
		assign zs = st.z[g].state;
		assign no_arrto = opt(st.ctrl, g, zone_jam_pkg::OPT_NO_ARRTO);
		sequence s_sns_jam_enter;
			zs != zone_jam_pkg::ZS_JAM_SNS ##1 zs == zone_jam_pkg::ZS_JAM_SNS;
		endsequence
		sequence s_arr_jam_enter;
			zs != zone_jam_pkg::ZS_JAM_ARR ##1 zs == zone_jam_pkg::ZS_JAM_ARR;
		endsequence
		chk_bypass_arr: assert property (zs == zone_jam_pkg::ZS_JAM_ARR && opt(st.ctrl, g, zone_jam_pkg::OPT_BYP_ARR)
			|=> zs == zone_jam_pkg::ZS_EMPTY) else $error("arrival jam not cleared at once");
		chk_arr_detect: assert property (zs == zone_jam_pkg::ZS_WAIT_ARR && !dn_arr[g] && !no_arrto
			&& st.z[g].timer >= st.jam_time |=> zs == zone_jam_pkg::ZS_JAM_ARR
			&& st.z[g].count == $past(st.z[g].count) + 16'h0001 ##1 st.irq_st[2 * g]) else $error("arrival jam missed");
		chk_attempt_cap: assert property (s_sns_jam_enter |-> st.z[g].attempts <= zone_jam_pkg::MAX_ATTEMPTS
			&& $past(st.z[g].count) != st.z[g].count || $past(zs) == zone_jam_pkg::ZS_CLEAR_RUN)
			else $error("sensor jam entry wrong");
		chk_no_autoclear: assert property (zs == zone_jam_pkg::ZS_JAM_SNS && opt(st.ctrl, g, zone_jam_pkg::OPT_NO_AUTO)
			&& !st.clear_req[g] && sns[g] |=> zs == zone_jam_pkg::ZS_JAM_SNS) else $error("auto clear not disabled");
		chk_clear_cmd: assert property (zs == zone_jam_pkg::ZS_JAM_SNS && st.clear_req[g] && sns[g]
			|=> zs == zone_jam_pkg::ZS_CLEAR_RUN) else $error("clear command ignored");
		chk_bypass_sns: assert property (zs == zone_jam_pkg::ZS_JAM_SNS && sns[g]
			&& opt(st.ctrl, g, zone_jam_pkg::OPT_BYP_SNS) && !opt(st.ctrl, g, zone_jam_pkg::OPT_NO_AUTO)
			&& st.z[g].attempts < zone_jam_pkg::MAX_ATTEMPTS |=> zs == zone_jam_pkg::ZS_CLEAR_RUN)
			else $error("sensor jam delay not skipped");
		chk_no_arr_jam: assert property (s_arr_jam_enter |-> $past(no_arrto) == 1'b0) else $error("arrival jam while off");
		chk_fast_accept: assert property (zs == zone_jam_pkg::ZS_SEND && !sns[g] && no_arrto
			|=> zs == zone_jam_pkg::ZS_EMPTY) else $error("no fast accept");
		chk_lost_search: assert property (zs == zone_jam_pkg::ZS_EMPTY && lost_in[g] && !sns[g]
			&& !opt(st.ctrl, g, zone_jam_pkg::OPT_NO_MANUAL) |=> zs == zone_jam_pkg::ZS_SEARCH) else $error("no search");
		chk_no_search: assert property (zs == zone_jam_pkg::ZS_EMPTY && opt(st.ctrl, g, zone_jam_pkg::OPT_NO_MANUAL)
			|=> zs != zone_jam_pkg::ZS_SEARCH) else $error("search while disabled");
	end

	chk_port_map: assert property (motor_run_left == running(st.z[st.ctrl[zone_jam_pkg::LEFT_SEL_BIT]].state)
		&& motor_run_right == running(st.z[!st.ctrl[zone_jam_pkg::LEFT_SEL_BIT]].state)) else $error("motor port map");
endmodule // zone_jam_ctrl

/* File: tb/zone_neighbour_model.sv */
// Model of the neighbour modules and the downstream arrival report
`timescale 1ns/1ps
module zone_neighbour_model #(
	parameter int TICK = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench controls, mode 0 silent, 1 prompt, 2 slow
	input wire logic [1:0] mode,
	input wire logic stall,
	input wire logic lost_req,
	// Carton leaving the last zone
	input wire logic sensor_dn,
	// Links into the module
	output logic dn_arrived,
	output logic dn_ready,
	output logic up_lost
);
	logic prev;
	int arr_cnt;
	int lost_cnt;
	// Arrival reported after a lag and held two ticks; lost pulse stretched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev <= 1'b0;
			arr_cnt <= 0;
			lost_cnt <= 0;
			dn_arrived <= 1'b0;
			dn_ready <= 1'b0;
			up_lost <= 1'b0;
		end else begin
			prev <= sensor_dn;
			if (prev && !sensor_dn && mode != 2'h0) begin
				arr_cnt <= (mode == 2'h2) ? 5 * TICK : 3 * TICK;
			end else if (arr_cnt > 0) begin
				arr_cnt <= arr_cnt - 1;
			end
			dn_arrived <= arr_cnt > 0 && arr_cnt <= 2 * TICK;
			dn_ready <= !stall;
			lost_cnt <= lost_req ? 2 * TICK : (lost_cnt > 0 ? lost_cnt - 1 : 0);
			up_lost <= lost_cnt > 0;
		end
	end
endmodule // zone_neighbour_model

/* File: tb/test_zone_jam_ctrl.sv */
// Self-checking bench for the two-zone jam option logic
`timescale 1ns/1ps
module test_zone_jam_ctrl;
	localparam int TK = 4;
	localparam int IQ = 0;
	localparam int MR = 1;
	localparam int ML = 2;
	localparam int LD = 3;
	localparam int AU = 4;
	localparam int RU = 5;
	localparam logic [7:0] CT = zone_jam_pkg::OFS_CTRL;
	localparam logic [7:0] JT = zone_jam_pkg::OFS_JAM_TIME;
	localparam logic [7:0] CD = zone_jam_pkg::OFS_CLR_DELAY;
	localparam logic [7:0] CM = zone_jam_pkg::OFS_CMD;
	localparam logic [7:0] ST = zone_jam_pkg::OFS_STATUS;
	localparam logic [7:0] CN = zone_jam_pkg::OFS_COUNT;
	localparam logic [7:0] IS = zone_jam_pkg::OFS_IRQ_ST;
	localparam logic [7:0] IM = zone_jam_pkg::OFS_IRQ_MASK;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [1:0] zone_sensor = 2'h0;
	logic [1:0] zone_accumulate = 2'h0;
	logic [1:0] mode = 2'h1;
	logic stall = 1'b0;
	logic lost_req = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, dn_arrived, dn_ready, up_lost;
	logic arrived_to_up, ready_to_up, lost_to_dn, motor_run_left, motor_run_right, irq;
	int err_count = 0;
	int num_checks = 0;
	logic [15:0] cnt1 = 16'h0;
	wire [5:0] obs = {ready_to_up, arrived_to_up, lost_to_dn, motor_run_left, motor_run_right, irq};

	// Device and its neighbours
	zone_jam_ctrl #(.TICK_CYCLES(TK)) i_zone_jam_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .zone_sensor(zone_sensor), .zone_accumulate(zone_accumulate),
		.dn_arrived(dn_arrived), .dn_ready(dn_ready), .up_lost(up_lost), .arrived_to_up(arrived_to_up),
		.ready_to_up(ready_to_up), .lost_to_dn(lost_to_dn), .motor_run_left(motor_run_left),
		.motor_run_right(motor_run_right), .irq(irq));
	zone_neighbour_model #(.TICK(TK)) i_zone_neighbour_model (.pclk(pclk), .presetn(presetn), .mode(mode),
		.stall(stall), .lost_req(lost_req), .sensor_dn(zone_sensor[1]), .dn_arrived(dn_arrived),
		.dn_ready(dn_ready), .up_lost(up_lost));

	// Clock
	initial begin
		forever #2.5 pclk = ~pclk;
	end

	// Verdict and end of run
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Comparison with count and report
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// One APB transfer, waiting for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			chk({31'h0, pready}, 32'h1);
			tally_and_finish();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r & m, v);
	endtask

	// Bounded waits on outputs and on status bits
	task automatic wait_bit(input int i, input logic v, input int lim);
		int n;
		for (n = 0; n < lim && obs[i] !== v; n++) begin
			@(posedge pclk);
		end
		chk({31'h0, obs[i]}, {31'h0, v});
		if (obs[i] !== v) tally_and_finish();
	endtask

	task automatic hold_bit(input int i, input logic v, input int cyc);
		logic bad;
		bad = 1'b0;
		repeat (cyc) begin
			@(posedge pclk);
			if (obs[i] !== v) bad = 1'b1;
		end
		chk({31'h0, bad}, 32'h0);
	endtask

	task automatic poll_st(input logic [31:0] m, input logic [31:0] v);
		logic [31:0] r;
		logic e;
		int n;
		n = 0;
		do begin
			apb(1'b0, ST, 32'h0, r, e);
			n++;
		end while ((r & m) !== v && n < 40);
		chk(r & m, v);
		if ((r & m) !== v) tally_and_finish();
	endtask

	// Discharge one carton from the downstream zone
	task automatic send1(input int port);
		zone_sensor[1] <= 1'b1;
		wait_bit(port, 1'b1, 40);
		zone_sensor[1] <= 1'b0;
	endtask

	// Reset values, reserved bits, unmapped access, timing setup
	task automatic s_regs();
		logic [31:0] r;
		logic e;
		chk({31'h0, ready_to_up}, 32'h1);
		rd(CT, 32'hFFFF_FFFF, zone_jam_pkg::CTRL_RST);
		rd(JT, 32'hFFFF, {16'h0, zone_jam_pkg::JAM_TIME_RST});
		rd(CD, 32'hFFFF, {16'h0, zone_jam_pkg::CLR_DELAY_RST});
		rd(IM, 32'hFFFF_FFFF, 32'h0);
		rd(CN, 32'hFFFF_FFFF, 32'h0);
		wr(CT, 32'hFFFF_FFFF);
		rd(CT, 32'hFFFF_FFFF, 32'h0001_1F1F);
		wr(CT, 32'h0);
		apb(1'b0, 8'h20, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		wr(JT, 32'h5);
		wr(CD, 32'h3);
		wr(IM, 32'hF);
		rd(JT, 32'hFFFF, 32'h5);
	endtask

	// Arrival jam with and without the skipped clear delay
	task automatic s_arrival(input logic byp);
		mode <= 2'h0;
		wr(CT, byp ? 32'h100 : 32'h0);
		send1(MR);
		hold_bit(IQ, 1'b0, 12);
		wait_bit(IQ, 1'b1, 40);
		cnt1++;
		rd(ST, 32'h2, byp ? 32'h0 : 32'h2);
		rd(IS, 32'hF, 32'h4);
		rd(CN, 32'hFFFF_0000, {cnt1, 16'h0});
		wr(IS, 32'hF);
		wait_bit(IQ, 1'b0, 4);
		poll_st(32'h2, 32'h0);
	endtask

	// No arrival timeout: quick re-accept, never a jam
	task automatic s_no_timeout();
		wr(CT, 32'h800);
		send1(MR);
		repeat (4) @(posedge pclk);
		zone_sensor[1] <= 1'b1;
		wait_bit(MR, 1'b1, 12);
		zone_sensor[1] <= 1'b0;
		hold_bit(IQ, 1'b0, 60);
		rd(CN, 32'hFFFF_0000, {cnt1, 16'h0});
		mode <= 2'h1;
	endtask

	// Sensor jam: three automatic attempts with or without the clear delay, then a commanded one
	task automatic s_sensor(input logic byp);
		wr(CT, byp ? 32'h200 : 32'h0);
		zone_sensor[1] <= 1'b1;
		wait_bit(MR, 1'b1, 40);
		wait_bit(IQ, 1'b1, 60);
		cnt1++;
		wait_bit(MR, 1'b0, 8);
		repeat (3) begin
			if (!byp) hold_bit(MR, 1'b0, 6);
			wait_bit(MR, 1'b1, byp ? 4 : 60);
			wait_bit(MR, 1'b0, 4100);
		end
		hold_bit(MR, 1'b0, 4500);
		rd(ST, 32'hC2, 32'hC2);
		wr(IS, 32'hF);
		wr(CM, 32'h2);
		wait_bit(MR, 1'b1, 10);
		zone_sensor[1] <= 1'b0;
		poll_st(32'h2, 32'h0);
	endtask

	// No auto clear, with the interrupt masked then unmasked
	task automatic s_no_auto();
		wr(CT, 32'h400);
		wr(IM, 32'h0);
		zone_sensor[1] <= 1'b1;
		wait_bit(MR, 1'b1, 40);
		hold_bit(IQ, 1'b0, 60);
		rd(IS, 32'h8, 32'h8);
		cnt1++;
		hold_bit(MR, 1'b0, 200);
		rd(ST, 32'h2, 32'h2);
		wr(IM, 32'hF);
		wait_bit(IQ, 1'b1, 5);
		wr(IS, 32'hF);
		wait_bit(IQ, 1'b0, 5);
		zone_sensor[1] <= 1'b0;
		poll_st(32'h2, 32'h0);
		rd(CN, 32'hFFFF_0000, {cnt1, 16'h0});
	endtask

	// Lost carton search and its suppression
	task automatic s_lost();
		wr(CT, 32'h0);
		lost_req <= 1'b1;
		@(posedge pclk);
		lost_req <= 1'b0;
		wait_bit(ML, 1'b1, 30);
		wait_bit(ML, 1'b0, 60);
		wr(CT, 32'h10);
		lost_req <= 1'b1;
		@(posedge pclk);
		lost_req <= 1'b0;
		hold_bit(ML, 1'b0, 60);
		zone_accumulate[1] <= 1'b1;
		zone_sensor[1] <= 1'b1;
		repeat (10) @(posedge pclk);
		zone_sensor[1] <= 1'b0;
		wait_bit(LD, 1'b1, 20);
		zone_accumulate[1] <= 1'b0;
		repeat (20) @(posedge pclk);
		// Carton taken from the accumulated upstream zone makes the downstream zone search
		zone_accumulate[0] <= 1'b1;
		zone_sensor[0] <= 1'b1;
		wait_bit(AU, 1'b1, 10);
		chk({31'h0, ready_to_up}, 32'h0);
		zone_sensor[0] <= 1'b0;
		wait_bit(MR, 1'b1, 10);
		wait_bit(RU, 1'b1, 4);
		zone_accumulate[0] <= 1'b0;
		wait_bit(MR, 1'b0, 60);
	endtask

	// Port mapping swap, downstream stall, slow arrival
	task automatic s_swap();
		wr(CT, 32'h1_0000);
		mode <= 2'h2;
		stall <= 1'b1;
		zone_sensor[1] <= 1'b1;
		hold_bit(ML, 1'b0, 20);
		stall <= 1'b0;
		send1(ML);
		chk({31'h0, motor_run_right}, 32'h0);
		hold_bit(IQ, 1'b0, 40);
		rd(CN, 32'hFFFF_0000, {cnt1, 16'h0});
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		s_regs();
		s_arrival(1'b0);
		s_arrival(1'b1);
		s_no_timeout();
		s_sensor(1'b0);
		s_sensor(1'b1);
		s_no_auto();
		s_lost();
		s_swap();
		tally_and_finish();
	end
endmodule // test_zone_jam_ctrl
